// ### inc/pfs_pkg.sv
// Constants for the pin function select block with write lock.
// Assumes a 32-bit AXI4-Lite register bus and a single system clock.
package pfs_pkg;

	// ==========================================================
	// Bus and register map
	localparam int        ADDR_W      = 8;
	localparam int        DATA_W      = 32;
	localparam int        REG_W       = 16;
	localparam logic [7:0] IDX_PROTECT = 8'h12;
	localparam logic [7:0] IDX_PA_LOW  = 8'h13;
	localparam logic [7:0] IDX_PA_HIGH = 8'h14;
	localparam logic [7:0] IDX_PB_LOW  = 8'h15;
	localparam logic [7:0] ADDR_PROTECT = 8'(IDX_PROTECT * 4);
	localparam logic [7:0] ADDR_PA_LOW  = 8'(IDX_PA_LOW * 4);
	localparam logic [7:0] ADDR_PA_HIGH = 8'(IDX_PA_HIGH * 4);
	localparam logic [7:0] ADDR_PB_LOW  = 8'(IDX_PB_LOW * 4);
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Writable bits and reset values
	localparam logic [15:0] PROTECT_MASK  = 16'h000F;
	localparam logic [15:0] PA_LOW_MASK   = 16'h1F00;
	localparam logic [15:0] PA_HIGH_MASK  = 16'h005F;
	localparam logic [15:0] PB_LOW_MASK   = 16'h78F5;
	localparam logic [15:0] REG_RESET     = 16'h0000;

	// ==========================================================
	// Protection field layout
	localparam int CLK_PROT_LSB = 2;
	localparam int MUX_PROT_LSB = 0;
	localparam int PROT_ON_BIT  = 0;
	localparam int PROT_LOCK_BIT = 1;

	// ==========================================================
	// Managed pins: register (0 port A low, 1 port A high, 2 port B low),
	// field low bit and high-bit offset (0 for a one-bit field, 1 for a two-bit field) for each pin index.
	localparam int NUM_PINS  = 13;
	localparam int NUM_FUNCS = 24;
	// Pin order: A4 A5 A6 A8 A9 A10 A11 B0 B1 B2 B3 B5 B6.
	localparam int PIN_REG  [NUM_PINS] = '{0, 0, 0, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2};
	localparam int PIN_LSB  [NUM_PINS] = '{8, 10, 12, 0, 2, 4, 6, 0, 2, 4, 6, 11, 13};
	localparam int PIN_WIDE [NUM_PINS] = '{1, 1, 0, 1, 1, 0, 0, 0, 0, 1, 1, 1, 1};

	// ==========================================================
	// Peripheral function indices
	localparam logic [4:0] F_PWM_OUT_4      = 5'h00;
	localparam logic [4:0] F_PWM_OUT_5      = 5'h01;
	localparam logic [4:0] F_PWM_FAULT_IN_0 = 5'h02;
	localparam logic [4:0] F_PWM_FAULT_IN_1 = 5'h03;
	localparam logic [4:0] F_PWM_FAULT_IN_2 = 5'h04;
	localparam logic [4:0] F_PWM_FAULT_IN_3 = 5'h05;
	localparam logic [4:0] F_TIMER_A_CH0    = 5'h06;
	localparam logic [4:0] F_TIMER_A_CH1    = 5'h07;
	localparam logic [4:0] F_TIMER_A_CH2    = 5'h08;
	localparam logic [4:0] F_TIMER_A_CH3    = 5'h09;
	localparam logic [4:0] F_COMPARATOR_A_IN1 = 5'h0A;
	localparam logic [4:0] F_COMPARATOR_A_IN2 = 5'h0B;
	localparam logic [4:0] F_COMPARATOR_B_IN1 = 5'h0C;
	localparam logic [4:0] F_COMPARATOR_B_IN2 = 5'h0D;
	localparam logic [4:0] F_UART0_RECEIVE  = 5'h0E;
	localparam logic [4:0] F_EXTERNAL_CLOCK_INPUT = 5'h0F;
	localparam logic [4:0] F_SPI0_MASTER_OUT = 5'h10;
	localparam logic [4:0] F_SPI0_MASTER_IN  = 5'h11;
	localparam logic [4:0] F_SPI0_SLAVE_SELECT = 5'h12;
	localparam logic [4:0] F_SPI0_SERIAL_CLOCK = 5'h13;
	localparam logic [4:0] F_I2C_SDA        = 5'h14;
	localparam logic [4:0] F_I2C_SCL        = 5'h15;
	localparam logic [4:0] F_PWM_PAIR01_EXT_SOURCE = 5'h16;
	localparam logic [4:0] F_PWM_PAIR23_EXT_SOURCE = 5'h17;

	// Returns {valid, function index} for a pin and its select code.
	function automatic logic [5:0] pfs_route(input int pin, input logic [1:0] code);
		logic [5:0] r;
		r = 6'h00;
		case (pin)
			0: case (code)
				2'h0: r = {1'b1, F_PWM_OUT_4};
				2'h1: r = {1'b1, F_PWM_FAULT_IN_1};
				2'h2: r = {1'b1, F_TIMER_A_CH2};
				default: r = 6'h00;
			endcase
			1: case (code)
				2'h0: r = {1'b1, F_PWM_OUT_5};
				2'h1: r = {1'b1, F_PWM_FAULT_IN_2};
				2'h2: r = {1'b1, F_TIMER_A_CH3};
				default: r = 6'h00;
			endcase
			2: r = (code == 2'h0) ? {1'b1, F_PWM_FAULT_IN_0} : {1'b1, F_TIMER_A_CH0};
			3: case (code)
				2'h0: r = {1'b1, F_PWM_FAULT_IN_1};
				2'h1: r = {1'b1, F_TIMER_A_CH2};
				2'h2: r = {1'b1, F_COMPARATOR_A_IN1};
				default: r = 6'h00;
			endcase
			4: case (code)
				2'h0: r = {1'b1, F_PWM_FAULT_IN_2};
				2'h1: r = {1'b1, F_TIMER_A_CH3};
				2'h2: r = {1'b1, F_COMPARATOR_B_IN1};
				default: r = 6'h00;
			endcase
			5: r = (code == 2'h0) ? {1'b1, F_COMPARATOR_A_IN2} : 6'h00;
			6: r = (code == 2'h0) ? {1'b1, F_COMPARATOR_B_IN2} : 6'h00;
			7: r = (code == 2'h0) ? {1'b1, F_SPI0_SERIAL_CLOCK} : {1'b1, F_I2C_SCL};
			8: r = (code == 2'h0) ? {1'b1, F_SPI0_SLAVE_SELECT} : {1'b1, F_I2C_SDA};
			9: case (code)
				2'h0: r = {1'b1, F_SPI0_MASTER_IN};
				2'h1: r = {1'b1, F_TIMER_A_CH2};
				2'h2: r = {1'b1, F_PWM_PAIR01_EXT_SOURCE};
				default: r = 6'h00;
			endcase
			10: case (code)
				2'h0: r = {1'b1, F_SPI0_MASTER_OUT};
				2'h1: r = {1'b1, F_TIMER_A_CH3};
				2'h2: r = {1'b1, F_PWM_PAIR23_EXT_SOURCE};
				default: r = 6'h00;
			endcase
			11: case (code)
				2'h0: r = {1'b1, F_TIMER_A_CH1};
				2'h1: r = {1'b1, F_PWM_FAULT_IN_3};
				2'h2: r = {1'b1, F_EXTERNAL_CLOCK_INPUT};
				default: r = 6'h00;
			endcase
			12: case (code)
				2'h0: r = {1'b1, F_UART0_RECEIVE};
				2'h1: r = {1'b1, F_I2C_SDA};
				2'h2: r = {1'b1, F_EXTERNAL_CLOCK_INPUT};
				default: r = 6'h00;
			endcase
			default: r = 6'h00;
		endcase
		return r;
	endfunction

endpackage

// ### rtl/pfs_pin_mux.sv
// Pin function select registers with write protection and lock, plus the
// pin and peripheral routing they steer.
// Assumes a 32-bit AXI4-Lite master, one clock and synchronous pad inputs.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Notes on behaviour
// - Clock protect field, bits 3-2, write-protects clock enable and control registers.
// - Mux protect field, bits 1-0, write-protects select, enable, mode, drive registers.
// - Field codes: 00 off, 01 on, 10 off locked, 11 on locked.
// - Locked field ignores writes; only chip reset returns it to 00.
// - Unlocked field may be turned off and on any number of times.
// - Mux protect field also guards the PWM test fields of clock output control.
// - Enable bit 0 gives pin to GPIO; 1 lets its select field choose.
// - Output fans out to all selected pins; input combines those pins.
// - After reset every managed pin is general-purpose I/O.
// - Port A pin 6, bit 12: fault input 0 or timer A channel 0.
// - Port A pin 5, bits 11-10: PWM 5, fault 2, timer A3; 11 reserved.
// - Port A pin 4, bits 9-8: PWM 4, fault 1, timer A2; 11 reserved.
// - Port A pins 11 and 10: comparator B and A input 2; 1 reserved.
// - Port A pin 9, bits 3-2: fault 2, timer A3, comparator B input 1.
// - Port A pin 8, bits 1-0: fault 1, timer A2, comparator A input 1.
// - Port B pin 6, bits 14-13: UART 0 receive, I2C data, external clock.
// - Port B pin 5, bits 12-11: timer A1, fault 3, external clock.
// - Port B pin 3, bits 7-6: SPI master out, timer A3, pair 2/3 source.
// - Port B pin 2, bits 5-4: SPI master in, timer A2, pair 0/1 source.
// - Port B pins 1 and 0: SPI select and clock, or I2C data and clock.
module pfs_pin_mux
	import pfs_pkg::*;
(
	// Clock and reset
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	// AXI4-Lite write address
	input  wire logic [ADDR_W-1:0]     awaddr,
	input  wire logic [2:0]            awprot,
	input  wire logic                  awvalid,
	output logic                       awready,
	// AXI4-Lite write data
	input  wire logic [DATA_W-1:0]     wdata,
	input  wire logic [DATA_W/8-1:0]   wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	// AXI4-Lite write response
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	// AXI4-Lite read address
	input  wire logic [ADDR_W-1:0]     araddr,
	input  wire logic [2:0]            arprot,
	input  wire logic                  arvalid,
	output logic                       arready,
	// AXI4-Lite read data
	output logic [DATA_W-1:0]          rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	// Write blocks for the clock and mux configuration held elsewhere
	output logic                       clock_ctrl_write_block,
	output logic                       mux_config_write_block,
	// Pins
	input  wire logic [NUM_PINS-1:0]   pin_peripheral_enable,
	input  wire logic [NUM_PINS-1:0]   gpio_out,
	input  wire logic [NUM_PINS-1:0]   gpio_oe,
	input  wire logic [NUM_PINS-1:0]   pad_in,
	output logic [NUM_PINS-1:0]        pad_out,
	output logic [NUM_PINS-1:0]        pad_oe,
	// Peripheral functions
	input  wire logic [NUM_FUNCS-1:0]  func_out,
	input  wire logic [NUM_FUNCS-1:0]  func_oe,
	output logic [NUM_FUNCS-1:0]       func_in
);

	// ==========================================================
	// Registers and bus state
	logic [REG_W-1:0]  config_write_protect;
	logic [REG_W-1:0]  port_a_low_function_select;
	logic [REG_W-1:0]  port_a_high_function_select;
	logic [REG_W-1:0]  port_b_low_function_select;
	logic              aw_full;
	logic              w_full;
	logic [ADDR_W-1:0] wr_addr;
	logic [REG_W-1:0]  wr_data;
	logic [1:0]        wr_strb;
	logic              do_write;
	logic [REG_W-1:0]  byte_mask;
	logic [1:0]        clock_ctrl_protect;
	logic [1:0]        mux_config_protect;
	logic              wr_hit;
	logic              rd_hit;
	logic [REG_W-1:0]  rd_value;
	logic [NUM_FUNCS-1:0] next_func_in;
	logic [5:0]        route [NUM_PINS];

	assign clock_ctrl_protect = config_write_protect[CLK_PROT_LSB +: 2];
	assign mux_config_protect = config_write_protect[MUX_PROT_LSB +: 2];
	assign do_write  = aw_full && w_full && !bvalid;
	assign byte_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	assign wr_hit    = (wr_addr == ADDR_PROTECT) || (wr_addr == ADDR_PA_LOW) ||
	                   (wr_addr == ADDR_PA_HIGH) || (wr_addr == ADDR_PB_LOW);

	// ==========================================================
	// Write address and data channels, taken in either order.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			wr_addr <= '0;
			wr_data <= '0;
			wr_strb <= 2'h0;
		end else begin
			if (awvalid && awready) begin
				aw_full <= 1'b1;
				awready <= 1'b0;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_full  <= 1'b1;
				wready  <= 1'b0;
				wr_data <= wdata[REG_W-1:0];
				wr_strb <= wstrb[1:0];
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
			end
			if (bvalid && bready) begin
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	// Protected writes still answer OKAY; only unmapped addresses fail.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Protection register. Each field takes a write only while its lock
	// bit is clear, so a locked field holds until chip reset.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			config_write_protect <= REG_RESET;
		end else if (do_write && wr_addr == ADDR_PROTECT && wr_strb[0]) begin
			if (!clock_ctrl_protect[PROT_LOCK_BIT]) begin
				config_write_protect[CLK_PROT_LSB +: 2] <= wr_data[CLK_PROT_LSB +: 2];
			end
			if (!mux_config_protect[PROT_LOCK_BIT]) begin
				config_write_protect[MUX_PROT_LSB +: 2] <= wr_data[MUX_PROT_LSB +: 2];
			end
		end
	end

	// Codes 01 and 11 protect; the lock bit does not change protection.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clock_ctrl_write_block <= 1'b0;
			mux_config_write_block <= 1'b0;
		end else begin
			clock_ctrl_write_block <= clock_ctrl_protect[PROT_ON_BIT];
			mux_config_write_block <= mux_config_protect[PROT_ON_BIT];
		end
	end

	// ==========================================================
	// Function select registers, frozen while mux protection is on.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port_a_low_function_select  <= REG_RESET;
			port_a_high_function_select <= REG_RESET;
			port_b_low_function_select  <= REG_RESET;
		end else if (do_write && !mux_config_protect[PROT_ON_BIT]) begin
			if (wr_addr == ADDR_PA_LOW) begin
				port_a_low_function_select <= (port_a_low_function_select & ~byte_mask) |
				                              (wr_data & byte_mask & PA_LOW_MASK);
			end
			if (wr_addr == ADDR_PA_HIGH) begin
				port_a_high_function_select <= (port_a_high_function_select & ~byte_mask) |
				                               (wr_data & byte_mask & PA_HIGH_MASK);
			end
			if (wr_addr == ADDR_PB_LOW) begin
				port_b_low_function_select <= (port_b_low_function_select & ~byte_mask) |
				                              (wr_data & byte_mask & PB_LOW_MASK);
			end
		end
	end

	// ==========================================================
	// Read channel; reserved bits are never stored, so they read zero.
	always_comb begin
		rd_hit   = 1'b1;
		rd_value = '0;
		case (araddr)
			ADDR_PROTECT: rd_value = config_write_protect;
			ADDR_PA_LOW:  rd_value = port_a_low_function_select;
			ADDR_PA_HIGH: rd_value = port_a_high_function_select;
			ADDR_PB_LOW:  rd_value = port_b_low_function_select;
			default:      rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= '0;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= {{(DATA_W-REG_W){1'b0}}, rd_value};
			rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
		end
	end

	// ==========================================================
	// Per-pin routing. A pin with its enable clear stays GPIO; a pin
	// with a reserved code drives nothing and feeds no peripheral.
	for (genvar p = 0; p < NUM_PINS; p++) begin : g_pin
		logic [REG_W-1:0] sel_reg;
		logic [1:0]       code;

		assign sel_reg = (PIN_REG[p] == 0) ? port_a_low_function_select :
		                 (PIN_REG[p] == 1) ? port_a_high_function_select :
		                                     port_b_low_function_select;
		assign code  = {(PIN_WIDE[p] != 0) ? sel_reg[PIN_LSB[p] + PIN_WIDE[p]] : 1'b0,
		                sel_reg[PIN_LSB[p]]};
		assign route[p] = pfs_route(p, code);

		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				pad_out[p] <= 1'b0;
				pad_oe[p]  <= 1'b0;
			end else if (!pin_peripheral_enable[p]) begin
				pad_out[p] <= gpio_out[p];
				pad_oe[p]  <= gpio_oe[p];
			end else if (route[p][5]) begin
				pad_out[p] <= func_out[route[p][4:0]];
				pad_oe[p]  <= func_oe[route[p][4:0]];
			end else begin
				pad_out[p] <= 1'b0;
				pad_oe[p]  <= 1'b0;
			end
		end
	end

	// Several pins on one function are ORed together; software is
	// expected to pick only one, and any switch over must allow a gap.
	always_comb begin
		next_func_in = '0;
		for (int f = 0; f < NUM_FUNCS; f++) begin
			for (int q = 0; q < NUM_PINS; q++) begin
				if (pin_peripheral_enable[q] && route[q][5] && route[q][4:0] == 5'(f)) begin
					next_func_in[f] = next_func_in[f] | pad_in[q];
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			func_in <= '0;
		end else begin
			func_in <= next_func_in;
		end
	end

endmodule

// ### tb/pfs_checker.sv
// Port assertions for the pin function select block.
// Assumes one clock domain; bound to the design's top module.
`timescale 1ns/1ps
module pfs_checker
	import pfs_pkg::*;
(
	// Observed ports
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                awvalid,
	input wire logic                awready,
	input wire logic                wvalid,
	input wire logic                wready,
	input wire logic [1:0]          bresp,
	input wire logic                bvalid,
	input wire logic                bready,
	input wire logic                arvalid,
	input wire logic                arready,
	input wire logic [DATA_W-1:0]   rdata,
	input wire logic                rvalid,
	input wire logic                rready,
	input wire logic                clock_ctrl_write_block,
	input wire logic                mux_config_write_block,
	input wire logic [NUM_PINS-1:0] pin_peripheral_enable,
	input wire logic [NUM_PINS-1:0] gpio_out,
	input wire logic [NUM_PINS-1:0] pad_out
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence wr_taken_s;
		awvalid && awready && wvalid && wready;
	endsequence
	sequence blk_moved_s;
		$changed(mux_config_write_block) || $changed(clock_ctrl_write_block);
	endsequence
	reset_idle_a: assert property ($rose(aresetn) |-> !bvalid && !rvalid && pad_out == '0)
		else $error("bus or pads busy after reset");
	b_latency_a: assert property (wr_taken_s |-> ##2 bvalid)
		else $error("write answer late");
	w_refuse_a: assert property (wr_taken_s |=> !awready && !wready)
		else $error("write channels ready while busy");
	b_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	b_code_a: assert property (bvalid |-> bresp == RESP_OKAY || bresp == RESP_SLVERR)
		else $error("write response code illegal");
	r_answer_a: assert property (arvalid && arready |=> rvalid && rdata[31:16] == '0)
		else $error("read answer late or upper half set");
	r_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
	gpio_path_a: assert property ($past(aresetn) |->
		((pad_out ^ $past(gpio_out)) & ~$past(pin_peripheral_enable)) == '0)
		else $error("pad ignores general-purpose drive");
	block_cause_a: assert property ($past(aresetn) ##0 blk_moved_s |-> $past(bvalid))
		else $error("write block moved without a write");
endmodule

bind pfs_pin_mux pfs_checker u_pfs_checker (
	.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bresp, .bvalid, .bready,
	.arvalid, .arready, .rdata, .rvalid, .rready, .clock_ctrl_write_block,
	.mux_config_write_block, .pin_peripheral_enable, .gpio_out, .pad_out
);

// ### tb/pfs_pad_model.sv
// Pad model: resolves each pad from the block's drive and an outside driver.
// Assumes the bench sets the outside drive; a floating pad changes every cycle.
`timescale 1ns/1ps
module pfs_pad_model
	import pfs_pkg::*;
(
	// Clock
	input wire logic                aclk,
	// Block side
	input wire logic [NUM_PINS-1:0] pad_out,
	input wire logic [NUM_PINS-1:0] pad_oe,
	output logic [NUM_PINS-1:0]     pad_in,
	// Outside drivers
	input wire logic [NUM_PINS-1:0] ext_en,
	input wire logic [NUM_PINS-1:0] ext_val
);
	logic [NUM_PINS-1:0] float_pat = '0;
	always_ff @(posedge aclk) begin
		float_pat <= ~float_pat;
	end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ((ext_en & ext_val) | (~ext_en & float_pat)));
endmodule

// ### tb/tb_top.sv
// Self-checking bench for the pin function select block.
// Assumes the bound checker and the pad model beside the design.
`timescale 1ns/1ps
module tb_top;
	import pfs_pkg::*;
	typedef struct packed {
		logic [3:0] pin;
		logic [1:0] code;
		logic [4:0] fn;
	} pfs_row_t;
	logic                 aclk = 1'b0;
	logic                 aresetn = 1'b0;
	logic [ADDR_W-1:0]    awaddr = '0, araddr = '0;
	logic [2:0]           prot = 3'h0;
	logic                 awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic                 arvalid = 1'b0, rready = 1'b0;
	logic [DATA_W-1:0]    wdata = '0;
	logic [DATA_W/8-1:0]  wstrb = 4'h3;
	logic                 awready, wready, bvalid, arready, rvalid;
	logic [1:0]           bresp, rresp;
	logic [DATA_W-1:0]    rdata;
	logic                 clock_ctrl_write_block, mux_config_write_block;
	logic [1:0]           blocks;
	logic [NUM_PINS-1:0]  pin_peripheral_enable = '0, gpio_out = '0, gpio_oe = '0;
	logic [NUM_PINS-1:0]  pad_in, pad_out, pad_oe, ext_en = '0, ext_val = '0;
	logic [NUM_FUNCS-1:0] func_out = '0, func_oe = '0, func_in;
	logic [15:0]          masks [3] = '{PA_LOW_MASK, PA_HIGH_MASK, PB_LOW_MASK};
	int                   err_total = 0;
	int                   checks = 0;
	localparam pfs_row_t ROWS [32] = '{
		'{4'd0, 2'd0, F_PWM_OUT_4}, '{4'd0, 2'd1, F_PWM_FAULT_IN_1}, '{4'd0, 2'd2, F_TIMER_A_CH2},
		'{4'd1, 2'd0, F_PWM_OUT_5}, '{4'd1, 2'd1, F_PWM_FAULT_IN_2}, '{4'd1, 2'd2, F_TIMER_A_CH3},
		'{4'd2, 2'd0, F_PWM_FAULT_IN_0}, '{4'd2, 2'd1, F_TIMER_A_CH0},
		'{4'd3, 2'd0, F_PWM_FAULT_IN_1}, '{4'd3, 2'd1, F_TIMER_A_CH2},
		'{4'd3, 2'd2, F_COMPARATOR_A_IN1}, '{4'd4, 2'd0, F_PWM_FAULT_IN_2},
		'{4'd4, 2'd1, F_TIMER_A_CH3}, '{4'd4, 2'd2, F_COMPARATOR_B_IN1},
		'{4'd5, 2'd0, F_COMPARATOR_A_IN2}, '{4'd6, 2'd0, F_COMPARATOR_B_IN2},
		'{4'd7, 2'd0, F_SPI0_SERIAL_CLOCK}, '{4'd7, 2'd1, F_I2C_SCL},
		'{4'd8, 2'd0, F_SPI0_SLAVE_SELECT}, '{4'd8, 2'd1, F_I2C_SDA},
		'{4'd9, 2'd0, F_SPI0_MASTER_IN}, '{4'd9, 2'd1, F_TIMER_A_CH2},
		'{4'd9, 2'd2, F_PWM_PAIR01_EXT_SOURCE}, '{4'd10, 2'd0, F_SPI0_MASTER_OUT},
		'{4'd10, 2'd1, F_TIMER_A_CH3}, '{4'd10, 2'd2, F_PWM_PAIR23_EXT_SOURCE},
		'{4'd11, 2'd0, F_TIMER_A_CH1}, '{4'd11, 2'd1, F_PWM_FAULT_IN_3},
		'{4'd11, 2'd2, F_EXTERNAL_CLOCK_INPUT}, '{4'd12, 2'd0, F_UART0_RECEIVE},
		'{4'd12, 2'd1, F_I2C_SDA}, '{4'd12, 2'd2, F_EXTERNAL_CLOCK_INPUT}};
	assign blocks = {clock_ctrl_write_block, mux_config_write_block};
	initial begin
		forever #10 aclk = ~aclk;
	end
	pfs_pin_mux u_pfs_pin_mux (
		.aclk, .aresetn, .awaddr, .awprot(prot), .awvalid, .awready, .wdata, .wstrb, .wvalid,
		.wready, .bresp, .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready, .rdata,
		.rresp, .rvalid, .rready, .clock_ctrl_write_block, .mux_config_write_block,
		.pin_peripheral_enable, .gpio_out, .gpio_oe, .pad_in, .pad_out, .pad_oe,
		.func_out, .func_oe, .func_in);
	pfs_pad_model u_pfs_pad_model (.aclk, .pad_out, .pad_oe, .pad_in, .ext_en, .ext_val);
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			err_total++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask
	task automatic summarize();
		if (err_total == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	task automatic rst();
		aresetn <= 1'b0;
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
	endtask
	// Each channel is released at the edge that takes it; the answer is awaited.
	task automatic wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] er);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		awaddr <= a;
		wdata <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(ta && tw)) begin
			@(posedge aclk);
			ta = ta | awready;
			tw = tw | wready;
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b1;
		@(posedge aclk);
		bready <= 1'b0;
		chk("bresp", 32'(bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b1;
		@(posedge aclk);
		rready <= 1'b0;
		chk("rdata", rdata, ed);
		chk("rresp", 32'(rresp), 32'(er));
	endtask
	task automatic route(input pfs_row_t r, input logic ok);
		logic [12:0] pm;
		logic [23:0] fm;
		pm = 13'(1) << r.pin;
		fm = ok ? 24'(1) << r.fn : '1;
		wr(8'(ADDR_PA_LOW + 4 * PIN_REG[r.pin]), 16'(r.code) << PIN_LSB[r.pin], RESP_OKAY);
		pin_peripheral_enable <= pm;
		func_out <= fm;
		func_oe <= fm;
		repeat (3) @(posedge aclk);
		chk("pad_out", 32'(pad_out), ok ? 32'(pm) : 32'h0);
		chk("pad_oe", 32'(pad_oe), ok ? 32'(pm) : 32'h0);
		chk("func_in", 32'(func_in), ok ? 32'(fm) : 32'h0);
		pin_peripheral_enable <= '0;
		repeat (2) @(posedge aclk);
	endtask
	initial begin
		repeat (20000) @(posedge aclk);
		err_total++;
		summarize();
	end
	initial begin
		rst();
		gpio_out <= 13'h1A5A;
		gpio_oe <= 13'h0F0F;
		repeat (2) @(posedge aclk);
		chk("gpio pad_out", 32'(pad_out), 32'h1A5A);
		chk("gpio pad_oe", 32'(pad_oe), 32'h0F0F);
		gpio_out <= '0;
		gpio_oe <= '0;
		for (int k = 0; k < 3; k++) begin
			rd(8'(ADDR_PA_LOW + 4 * k), 32'h0, RESP_OKAY);
			wr(8'(ADDR_PA_LOW + 4 * k), 16'hFFFF, RESP_OKAY);
			rd(8'(ADDR_PA_LOW + 4 * k), 32'(masks[k]), RESP_OKAY);
		end
		for (int i = 0; i < 32; i++) begin
			route(ROWS[i], 1'b1);
		end
		for (int p = 0; p < NUM_PINS; p++) begin
			if (PIN_WIDE[p] == 1 || p == 5 || p == 6) begin
				route('{4'(p), PIN_WIDE[p] == 1 ? 2'd3 : 2'd1, 5'h00}, 1'b0);
			end
		end
		wr(ADDR_PA_LOW, 16'h0100, RESP_OKAY);
		wr(ADDR_PROTECT, 16'h0001, RESP_OKAY);
		wr(ADDR_PA_LOW, 16'h1F00, RESP_OKAY);
		rd(ADDR_PA_LOW, 32'h0100, RESP_OKAY);
		chk("mux block", 32'(blocks), 32'h1);
		wr(ADDR_PROTECT, 16'h0004, RESP_OKAY);
		wr(ADDR_PA_LOW, 16'h0000, RESP_OKAY);
		rd(ADDR_PA_LOW, 32'h0, RESP_OKAY);
		chk("clock block", 32'(blocks), 32'h2);
		wr(ADDR_PROTECT, 16'h000B, RESP_OKAY);
		wr(ADDR_PROTECT, 16'h0000, RESP_OKAY);
		rd(ADDR_PROTECT, 32'hB, RESP_OKAY);
		wr(ADDR_PA_LOW, 16'h0300, RESP_OKAY);
		rd(ADDR_PA_LOW, 32'h0, RESP_OKAY);
		chk("locked blocks", 32'(blocks), 32'h1);
		rst();
		rd(ADDR_PROTECT, 32'h0, RESP_OKAY);
		wr(ADDR_PROTECT, 16'h000E, RESP_OKAY);
		wr(ADDR_PROTECT, 16'h0001, RESP_OKAY);
		rd(ADDR_PROTECT, 32'hE, RESP_OKAY);
		wr(ADDR_PA_LOW, 16'h0100, RESP_OKAY);
		rd(ADDR_PA_LOW, 32'h0100, RESP_OKAY);
		chk("locked blocks", 32'(blocks), 32'h2);
		wstrb <= 4'h2;
		wr(ADDR_PB_LOW, 16'hFFFF, RESP_OKAY);
		wstrb <= 4'h3;
		rd(ADDR_PB_LOW, 32'h7800, RESP_OKAY);
		pin_peripheral_enable <= 13'h0009;
		func_out <= 24'(1) << F_PWM_FAULT_IN_1;
		func_oe <= 24'(1) << F_PWM_FAULT_IN_1;
		repeat (3) @(posedge aclk);
		chk("fan out", 32'(pad_out & pad_oe), 32'h9);
		func_oe <= '0;
		ext_en <= 13'h0009;
		ext_val <= 13'h0008;
		repeat (3) @(posedge aclk);
		chk("merged input", 32'(func_in[F_PWM_FAULT_IN_1]), 32'h1);
		ext_val <= '0;
		repeat (3) @(posedge aclk);
		chk("merged input", 32'(func_in[F_PWM_FAULT_IN_1]), 32'h0);
		wr(8'h00, 16'h1234, RESP_SLVERR);
		rd(8'h00, 32'h0, RESP_SLVERR);
		summarize();
	end
endmodule
